// ### core/pwmcs_top.sv
/*
 * Eight-channel PWM with two prescaled clocks A and B, two scaled clocks,
 * per-channel clock choice, polarity and pair concatenation.
 * Assumes one bus clock, a single-cycle register port and outputs to pins.
 */
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps

// Contract
// R01 - A disabled channel stays idle and an enabled one starts on its next clock tick.
// R02 - A concatenated pair forces the lower channel output off whatever its enable.
// R03 - Enable bits of absent channels ignore writes and read zero.
// R04 - Polarity one starts each period high then drops at duty, zero the reverse.
// R05 - Clock A ticks an 8-bit down counter that pulses and reloads at one.
// R06 - The A pulse train is halved by a toggle, giving A over twice the scale.
// R07 - A scale value of zero counts as 256, dividing the source by 512.
// R08 - Clock B drives its own down counter and toggle in the same way.
// R09 - Writing a scale register reloads its down counter at once.
// R10 - Software should not rewrite scale registers while channels run.
// R11 - Each channel picks clock A, scaled A, B or scaled B from two select bits.
// R12 - Reset selects clock A for channels 0, 1, 4, 5 and B for 2, 3, 6, 7.
// R13 - Software should not change clock choices while channels run.
// R14 - Clocks A and B come from the bus clock through power-of-two prescalers.
module pwmcs_top
#(
    parameter int NUM_CH = pwmcs_pkg::PWMCS_CHANNELS
)(
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    input  wire logic [pwmcs_pkg::PWMCS_AW-1:0] reg_addr,
    input  wire logic [pwmcs_pkg::PWMCS_DW-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [pwmcs_pkg::PWMCS_DW-1:0] reg_rdata,
    output logic      [7:0]                     pwm_out
);
    import pwmcs_pkg::*;

    // Mask and outputs are eight wide; more channels cannot be served
    if (NUM_CH < 1 || NUM_CH > PWMCS_CHANNELS)
    begin : g_bad_num_ch
        $error("NUM_CH must be 1 to 8");
    end

    localparam logic [7:0] CH_MASK = 8'((9'h1 << NUM_CH) - 9'h1);

    function automatic logic [7:0] scale_load(input logic [7:0] v);
        scale_load = v;
    endfunction

    function automatic logic is_wr(input logic [3:0] a, input logic [3:0] o,
                                   input logic w);
        is_wr = w && (a == o);
    endfunction

    logic [7:0] enable_q, enable_d, polarity_q, polarity_d;
    logic [7:0] choice_q, choice_d, pairsel_q, pairsel_d;
    logic [7:0] prescale_q, prescale_d, concat_q, concat_d;
    logic [7:0] scale_a_q, scale_a_d, scale_b_q, scale_b_d;
    logic [7:0] period_q, period_d, duty_q, duty_d;
    logic [7:0] rdata_d;
    logic [PWMCS_PRE_WIDTH-1:0] pre_q, pre_d;
    logic       tick_a, tick_b, prev_a_q, prev_b_q;
    logic [7:0] cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d;
    logic       tog_a_q, tog_a_d, tog_b_q, tog_b_d;
    logic       stick_a, stick_b, psa_q, psb_q;
    logic [7:0] ch_tick;
    logic [7:0] ch_cnt_q [8];
    logic [7:0] ch_cnt_d [8];
    logic [7:0] run_q, run_d, out_q, out_d;

    // Register writes and reads
    always_comb
    begin
        enable_d   = enable_q;
        polarity_d = polarity_q;
        choice_d   = choice_q;
        pairsel_d  = pairsel_q;
        prescale_d = prescale_q;
        concat_d   = concat_q;
        scale_a_d  = scale_a_q;
        scale_b_d  = scale_b_q;
        period_d   = period_q;
        duty_d     = duty_q;
        if (is_wr(reg_addr, PWMCS_OFF_ENABLE, reg_wr))
            enable_d = reg_wdata & CH_MASK;                  // see R03
        if (is_wr(reg_addr, PWMCS_OFF_POLARITY, reg_wr))
            polarity_d = reg_wdata & CH_MASK;
        if (is_wr(reg_addr, PWMCS_OFF_CHOICE, reg_wr))
            choice_d = reg_wdata & CH_MASK;
        if (is_wr(reg_addr, PWMCS_OFF_PAIRSEL, reg_wr))
            pairsel_d = reg_wdata & CH_MASK;
        if (is_wr(reg_addr, PWMCS_OFF_PRESCALE, reg_wr))
            prescale_d = {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
        if (is_wr(reg_addr, PWMCS_OFF_CONCAT, reg_wr))
            concat_d = {4'h0, reg_wdata[3:0]};
        if (is_wr(reg_addr, PWMCS_OFF_SCALE_A, reg_wr))
            scale_a_d = reg_wdata;
        if (is_wr(reg_addr, PWMCS_OFF_SCALE_B, reg_wr))
            scale_b_d = reg_wdata;
        if (is_wr(reg_addr, PWMCS_OFF_PERIOD0, reg_wr))
            period_d = reg_wdata;
        if (is_wr(reg_addr, PWMCS_OFF_DUTY0, reg_wr))
            duty_d = reg_wdata;
        unique case (reg_addr)
            PWMCS_OFF_ENABLE:   rdata_d = enable_q;
            PWMCS_OFF_POLARITY: rdata_d = polarity_q;
            PWMCS_OFF_CHOICE:   rdata_d = choice_q;
            PWMCS_OFF_PAIRSEL:  rdata_d = pairsel_q;
            PWMCS_OFF_PRESCALE: rdata_d = prescale_q;
            PWMCS_OFF_CONCAT:   rdata_d = concat_q;
            PWMCS_OFF_SCALE_A:  rdata_d = scale_a_q;
            PWMCS_OFF_SCALE_B:  rdata_d = scale_b_q;
            PWMCS_OFF_PERIOD0:  rdata_d = period_q;
            PWMCS_OFF_DUTY0:    rdata_d = duty_q;
            default:            rdata_d = 8'h00;
        endcase
        if (!reg_rd)
            rdata_d = 8'h00;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q   <= 8'h00;
            polarity_q <= 8'h00;
            choice_q   <= PWMCS_RST_CHOICE;   // see R12
            pairsel_q  <= PWMCS_RST_PAIRSEL;  // see R12
            prescale_q <= 8'h00;
            concat_q   <= 8'h00;
            scale_a_q  <= PWMCS_RST_SCALE;
            scale_b_q  <= PWMCS_RST_SCALE;
            period_q   <= PWMCS_RST_PERIOD;
            duty_q     <= PWMCS_RST_DUTY;
            reg_rdata  <= 8'h00;
        end
        else
        begin
            enable_q   <= enable_d;
            polarity_q <= polarity_d;
            choice_q   <= choice_d;
            pairsel_q  <= pairsel_d;
            prescale_q <= prescale_d;
            concat_q   <= concat_d;
            scale_a_q  <= scale_a_d;
            scale_b_q  <= scale_b_d;
            period_q   <= period_d;
            duty_q     <= duty_d;
            reg_rdata  <= rdata_d;
        end
    end

    // Power-of-two prescaler; ticks on a rising edge of the chosen bit
    always_comb
    begin
        pre_d  = pre_q + 7'h01;
        tick_a = (prescale_q[2:0] == 3'h0) ? 1'b1
               : (pre_q[prescale_q[2:0] - 3'h1] && !prev_a_q);  // see R14
        tick_b = (prescale_q[6:4] == 3'h0) ? 1'b1
               : (pre_q[prescale_q[6:4] - 3'h1] && !prev_b_q);  // see R14
    end

    // Scaled paths: down counter then toggle
    always_comb
    begin
        cnt_a_d = cnt_a_q;
        tog_a_d = tog_a_q;
        stick_a = 1'b0;
        cnt_b_d = cnt_b_q;
        tog_b_d = tog_b_q;
        stick_b = 1'b0;
        if (is_wr(reg_addr, PWMCS_OFF_SCALE_A, reg_wr))
            cnt_a_d = scale_load(reg_wdata);                 // see R09
        else if (tick_a)
        begin
            if (cnt_a_q == 8'h01)
            begin
                cnt_a_d = scale_a_q;                         // see R05
                tog_a_d = !tog_a_q;                          // see R06
                stick_a = !tog_a_q;
            end
            else
                cnt_a_d = cnt_a_q - 8'h01;                   // see R07
        end
        if (is_wr(reg_addr, PWMCS_OFF_SCALE_B, reg_wr))
            cnt_b_d = scale_load(reg_wdata);                 // see R09
        else if (tick_b)
        begin
            if (cnt_b_q == 8'h01)
            begin
                cnt_b_d = scale_b_q;                         // see R08
                tog_b_d = !tog_b_q;
                stick_b = !tog_b_q;
            end
            else
                cnt_b_d = cnt_b_q - 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q    <= '0;
            prev_a_q <= 1'b0;
            prev_b_q <= 1'b0;
            cnt_a_q  <= 8'h00;
            cnt_b_q  <= 8'h00;
            tog_a_q  <= 1'b0;
            tog_b_q  <= 1'b0;
            psa_q    <= 1'b0;
            psb_q    <= 1'b0;
        end
        else
        begin
            pre_q    <= pre_d;
            prev_a_q <= (prescale_q[2:0] == 3'h0) ? 1'b0
                      : pre_q[prescale_q[2:0] - 3'h1];
            prev_b_q <= (prescale_q[6:4] == 3'h0) ? 1'b0
                      : pre_q[prescale_q[6:4] - 3'h1];
            cnt_a_q  <= cnt_a_d;
            cnt_b_q  <= cnt_b_d;
            tog_a_q  <= tog_a_d;
            tog_b_q  <= tog_b_d;
            psa_q    <= stick_a;
            psb_q    <= stick_b;
        end
    end

    // Channel clock choice and waveform
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            unique case ({pairsel_q[i], choice_q[i]})          // see R11
                2'b00: ch_tick[i] = (i[1] == 1'b0) ? tick_a : tick_b;
                2'b01: ch_tick[i] = (i[1] == 1'b0) ? psa_q : psb_q;
                2'b10: ch_tick[i] = (i[1] == 1'b0) ? tick_b : tick_a;
                2'b11: ch_tick[i] = (i[1] == 1'b0) ? psb_q : psa_q;
            endcase
            ch_cnt_d[i] = ch_cnt_q[i];
            run_d[i]    = run_q[i];
            out_d[i]    = out_q[i];
            if (!enable_q[i]
                || (concat_q[i/2] && PWMCS_PAIR_LOWER[i]))  // see R02
            begin
                run_d[i]    = 1'b0;                          // see R01
                ch_cnt_d[i] = 8'h00;
                out_d[i]    = 1'b0;
            end
            else if (ch_tick[i])
            begin
                run_d[i] = 1'b1;                             // see R01
                if (!run_q[i] || ch_cnt_q[i] >= period_q - 8'h01)
                begin
                    ch_cnt_d[i] = 8'h00;
                    out_d[i]    = polarity_q[i] ? (duty_q != 8'h00)
                                               : (duty_q == 8'h00);
                end
                else
                begin
                    ch_cnt_d[i] = ch_cnt_q[i] + 8'h01;
                    if (ch_cnt_d[i] == duty_q)
                        out_d[i] = !polarity_q[i];           // see R04
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q <= 8'h00;
            out_q <= 8'h00;
            for (int i = 0; i < 8; i++)
                ch_cnt_q[i] <= 8'h00;
        end
        else
        begin
            run_q <= run_d;
            out_q <= out_d;
            for (int i = 0; i < 8; i++)
                ch_cnt_q[i] <= ch_cnt_d[i];
        end
    end

    // Enabled outputs only; idle level is low regardless of polarity
    assign pwm_out = out_q & run_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence scale_a_wr_s;
        reg_wr && reg_addr == PWMCS_OFF_SCALE_A;
    endsequence

    scale_reload_a: assert property (scale_a_wr_s |=> cnt_a_q == $past(reg_wdata)) // see R09
        else $error("scale A write did not reload counter");
    absent_zero_a: assert property (reg_wr && reg_addr == PWMCS_OFF_ENABLE
        |=> (enable_q & ~CH_MASK) == 8'h00) // see R03
        else $error("absent enable bit set");
    disabled_idle_a: assert property (!enable_q[3] |=> !pwm_out[3]) // see R01
        else $error("disabled channel drives");
    concat_low_a: assert property (concat_q[0] |=> !pwm_out[0]) // see R02
        else $error("lower concatenated channel drives");
    reload_one_a: assert property (tick_a && cnt_a_q == 8'h01
        && !(reg_wr && reg_addr == PWMCS_OFF_SCALE_A)
        |=> cnt_a_q == scale_a_q && tog_a_q != $past(tog_a_q)) // see R05
        else $error("A counter missed reload or toggle");
    count_down_a: assert property (tick_a && cnt_a_q > 8'h01
        && !(reg_wr && reg_addr == PWMCS_OFF_SCALE_A)
        |=> cnt_a_q == $past(cnt_a_q) - 8'h01) // see R05
        else $error("A counter missed decrement");
    zero_wrap_a: assert property (tick_a && cnt_a_q == 8'h00
        && !(reg_wr && reg_addr == PWMCS_OFF_SCALE_A)
        |=> cnt_a_q == 8'hff) // see R07
        else $error("zero scale not full count");
    count_b_a: assert property (tick_b && cnt_b_q == 8'h01
        && !(reg_wr && reg_addr == PWMCS_OFF_SCALE_B)
        |=> cnt_b_q == scale_b_q) // see R08
        else $error("B counter missed reload");
    pol_start_a: assert property (enable_q[1] && !concat_q[0] && run_q[1]
        && ch_tick[1] && ch_cnt_q[1] >= period_q - 8'h01 && duty_q != 8'h00
        && $stable(enable_q)
        |=> pwm_out[1] == $past(polarity_q[1])) // see R04
        else $error("period start level wrong");
endmodule

// ### inc/pwmcs_pkg.sv
/*
 * Constants for the eight-channel PWM with clock scaler: register offsets,
 * reset values and prescaler limits.
 * Assumes a byte-wide register port with offsets as word indices.
 */
package pwmcs_pkg;
    localparam int          PWMCS_CHANNELS     = 8;
    localparam int          PWMCS_AW           = 4;
    localparam int          PWMCS_DW           = 8;
    localparam logic [3:0]  PWMCS_OFF_ENABLE   = 4'h0;
    localparam logic [3:0]  PWMCS_OFF_POLARITY = 4'h1;
    localparam logic [3:0]  PWMCS_OFF_CHOICE   = 4'h2;
    localparam logic [3:0]  PWMCS_OFF_PAIRSEL  = 4'h3;
    localparam logic [3:0]  PWMCS_OFF_PRESCALE = 4'h4;
    localparam logic [3:0]  PWMCS_OFF_CONCAT   = 4'h5;
    localparam logic [3:0]  PWMCS_OFF_SCALE_A  = 4'h6;
    localparam logic [3:0]  PWMCS_OFF_SCALE_B  = 4'h7;
    localparam logic [3:0]  PWMCS_OFF_PERIOD0  = 4'h8;
    localparam logic [3:0]  PWMCS_OFF_DUTY0    = 4'h9;
    localparam logic [7:0]  PWMCS_RST_CHOICE   = 8'h00;
    localparam logic [7:0]  PWMCS_RST_PAIRSEL  = 8'h00;
    localparam logic [7:0]  PWMCS_RST_SCALE    = 8'h00;
    localparam logic [7:0]  PWMCS_RST_PERIOD   = 8'hff;
    localparam logic [7:0]  PWMCS_RST_DUTY     = 8'h80;
    localparam logic [7:0]  PWMCS_PAIR_LOWER   = 8'h55;
    localparam int          PWMCS_PRE_BITS     = 3;
    localparam int          PWMCS_PRE_WIDTH    = 7;
endpackage

// ### dv/pwmcs_load.sv
/*
 * Load model on the eight PWM output pins: measures period, high time
 * and rising edge count of each channel in bus clock cycles.
 * Assumes pwm_out is registered on ref_clk and driven by the design only.
 */
`timescale 1ns/1ps
module pwmcs_load (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       pwm_out,
    output logic      [7:0][15:0] per_len,
    output logic      [7:0][15:0] hi_len,
    output logic      [7:0][15:0] rise_cnt
);
    logic [7:0]       prev_q;
    logic [7:0][15:0] since_q;

    // Pure observer; a load has nothing to obey on a push-pull pin
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q   <= '0;
            since_q  <= '0;
            per_len  <= '0;
            hi_len   <= '0;
            rise_cnt <= '0;
        end
        else
        begin
            prev_q <= pwm_out;
            for (int i = 0; i < 8; i++)
            begin
                since_q[i] <= since_q[i] + 16'h1;
                if (pwm_out[i] && !prev_q[i])
                begin
                    per_len[i]  <= since_q[i] + 16'h1;
                    since_q[i]  <= '0;
                    rise_cnt[i] <= rise_cnt[i] + 16'h1;
                end
                if (!pwm_out[i] && prev_q[i])
                    hi_len[i] <= since_q[i] + 16'h1;
            end
        end
    end
endmodule

// ### dv/pwmcs_top_tb_top.sv
/*
 * Register-level tests of the PWM clock scaler, six channels built.
 * Assumes the single-cycle register port and the index map of the package.
 */
`timescale 1ns/1ps
module pwmcs_top_tb_top;
    import pwmcs_pkg::*;
    localparam int          NCH = 6;
    localparam logic [7:0]  PER = 8'h04;
    localparam logic [7:0]  DUT = 8'h01;
    logic                   ref_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic [PWMCS_AW-1:0]    reg_addr = '0;
    logic [PWMCS_DW-1:0]    reg_wdata = '0;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [PWMCS_DW-1:0]    reg_rdata;
    logic [7:0]             pwm_out;
    logic [7:0][15:0]       per_len;
    logic [7:0][15:0]       hi_len;
    logic [7:0][15:0]       rise_cnt;
    logic [15:0]            mark;
    int                     miscompares = 0;
    int                     n_compared = 0;

    always #5 ref_clk = ~ref_clk;

    pwmcs_top #(.NUM_CH(NCH)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
    pwmcs_load u_load (.ref_clk(ref_clk), .rst_n(rst_n), .pwm_out(pwm_out),
        .per_len(per_len), .hi_len(hi_len), .rise_cnt(rise_cnt));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Channels are stopped around every reconfiguration to stay glitch free
    task automatic run_ch(input int ch, input logic [1:0] code,
                          input logic pol, input int div);
        wr(PWMCS_OFF_ENABLE, 8'h00);
        wr(PWMCS_OFF_CHOICE, 8'(code[0]) << ch);
        wr(PWMCS_OFF_PAIRSEL, 8'(code[1]) << ch);
        wr(PWMCS_OFF_POLARITY, 8'(pol) << ch);
        wr(PWMCS_OFF_ENABLE, 8'h01 << ch);
        repeat (4 * PER * div + 20) @(posedge ref_clk);
        chk(per_len[ch], 16'(PER * div));
        chk(hi_len[ch], 16'((pol ? DUT : PER - DUT) * div));
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #500000;
        miscompares++;
        test_done();
    end

    initial
    begin
        logic [7:0] d;
        logic [7:0] rst_tab [10];
        int         div_tab [4];
        rst_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                    8'hff, 8'h80};
        div_tab = '{2, 12, 4, 8};
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            rd(4'(i), d);
            chk(16'(d), 16'(rst_tab[i]));
        end
        rd(4'hf, d);
        chk(16'(d), 16'h0000);
        $display("test reset values done");
        wr(PWMCS_OFF_ENABLE, 8'hff);
        rd(PWMCS_OFF_ENABLE, d);
        chk(16'(d), 16'h003f);
        repeat (1100) @(posedge ref_clk);
        chk(rise_cnt[7], 16'h0000);
        chk(rise_cnt[6], 16'h0000);
        $display("test absent channels done");
        wr(PWMCS_OFF_PERIOD0, PER);
        wr(PWMCS_OFF_DUTY0, DUT);
        wr(PWMCS_OFF_PRESCALE, 8'h21);
        wr(PWMCS_OFF_SCALE_A, 8'h03);
        wr(PWMCS_OFF_SCALE_B, 8'h01);
        for (int c = 0; c < 4; c++)
            run_ch(1, 2'(c), 1'b1, div_tab[c]);
        run_ch(0, 2'b00, 1'b0, 2);
        run_ch(2, 2'b00, 1'b1, 4);
        $display("test clock choice and polarity done");
        wr(PWMCS_OFF_SCALE_A, 8'h00);
        run_ch(1, 2'b01, 1'b1, 1024);
        // Deliberate scale rewrite while running, only to observe reload
        mark = rise_cnt[1];
        wr(PWMCS_OFF_SCALE_A, 8'h03);
        repeat (100) @(posedge ref_clk);
        chk(16'(rise_cnt[1] > mark), 16'h0001);
        $display("test full scale and reload done");
        wr(PWMCS_OFF_ENABLE, 8'h00);
        wr(PWMCS_OFF_CONCAT, 8'h01);
        wr(PWMCS_OFF_CHOICE, 8'h00);
        wr(PWMCS_OFF_PAIRSEL, 8'h00);
        wr(PWMCS_OFF_ENABLE, 8'h03);
        mark = rise_cnt[0];
        repeat (40) @(posedge ref_clk);
        #1;
        chk(rise_cnt[0], mark);
        chk(16'(pwm_out[0]), 16'h0000);
        chk(per_len[1], 16'(PER * 2));
        wr(PWMCS_OFF_ENABLE, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        chk(16'(pwm_out), 16'h0000);
        $display("test concat and disable done");
        test_done();
    end
endmodule
